// ### rtl/lcddmc_pkg.sv
// shared constants and types for the lcd dot-matrix control block
package lcddmc_pkg;
	localparam longint CLK_HZ = 100_000_000;
	// frame clock rates in mHz for frame select codes 0..3
	localparam longint FRAME_MHZ_0 = 32000;
	localparam longint FRAME_MHZ_1 = 21333;
	localparam longint FRAME_MHZ_2 = 16000;
	localparam longint FRAME_MHZ_3 = 8000;
	localparam longint LINES_PER_CLK = 32;
	localparam int LINE_DIV_0 = int'((CLK_HZ * 1000) / (FRAME_MHZ_0 * LINES_PER_CLK));
	localparam int LINE_DIV_1 = int'((CLK_HZ * 1000) / (FRAME_MHZ_1 * LINES_PER_CLK));
	localparam int LINE_DIV_2 = int'((CLK_HZ * 1000) / (FRAME_MHZ_2 * LINES_PER_CLK));
	localparam int LINE_DIV_3 = int'((CLK_HZ * 1000) / (FRAME_MHZ_3 * LINES_PER_CLK));
	localparam longint BOOST_HZ = 2000;
	localparam int BOOST_DIV = int'(CLK_HZ / (2 * BOOST_HZ));
	localparam int DIV_W = 21;
	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_SUPPLY = 16'hFF02;
	localparam logic [15:0] IDX_REGUL = 16'hFF03;
	localparam logic [15:0] IDX_CLKSEL = 16'hFF12;
	localparam logic [15:0] IDX_MODE = 16'hFF50;
	localparam logic [15:0] IDX_DUTY = 16'hFF51;
	localparam logic [15:0] IDX_CONTRAST = 16'hFF52;
	localparam int NREGS = 6;
	localparam int R_SUPPLY = 0;
	localparam int R_REGUL = 1;
	localparam int R_CLKSEL = 2;
	localparam int R_MODE = 3;
	localparam int R_DUTY = 4;
	localparam int R_CONTRAST = 5;
	localparam logic [3:0] REG_RESET = 4'h0;
	// bit positions
	localparam int BOOSTER_EN_BIT = 0;
	localparam int SRC_SEL_BIT = 2;
	localparam int REGUL_EN_BIT = 0;
	localparam int LOGIC_HL_BIT = 2;
	localparam int LCD_HL_BIT = 3;
	localparam int BOOST_SEL_LO = 0;
	localparam int FRAME_SEL_LO = 2;
	localparam int MODE_LO = 0;
	localparam int PAGE_BIT = 2;
	localparam logic [1:0] BOOST_ON = 2'h1;
	localparam logic [2:0] DUTY_32 = 3'h0;
	localparam logic [2:0] DUTY_24A = 3'h2;
	localparam logic [2:0] DUTY_24B = 3'h3;
	localparam logic [2:0] DUTY_16 = 3'h4;
	localparam logic [4:0] LAST_COM_32 = 5'h1F;
	localparam logic [4:0] LAST_COM_24 = 5'h17;
	localparam logic [4:0] LAST_COM_16 = 5'h0F;
	// display memory window: index F000..F3FF, bit 7 set marks a hole
	localparam logic [5:0] MEM_PAGE_HI = 6'h3C;
	localparam int MEM_HOLE_BIT = 7;
	localparam int MEM_WORDS = 512;
	localparam int SEG_EXTRA = 48;
	localparam int NSEG = 64;
	localparam int NCOM = 32;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_REVERSE, MODE_ALL_ON, MODE_ALL_OFF} lcddmc_mode_t;
endpackage

// ### rtl/lcddmc_scan_if.sv
// interface between the control block and its common-line scanner
`timescale 1ns/1ps
`default_nettype none
interface lcddmc_scan_if;
	logic [1:0] frameSel;
	logic halfRate;
	logic [4:0] lastCom;
	logic [4:0] comIdx;
	logic lineTick;
	logic frameStart;
	modport ctrl (output frameSel, output halfRate, output lastCom,
		input comIdx, input lineTick, input frameStart);
	modport scan (input frameSel, input halfRate, input lastCom,
		output comIdx, output lineTick, output frameStart);
endinterface
`default_nettype wire

// ### rtl/lcddmc_scan.sv
// common-line scanner: line-rate divider and common counter
`timescale 1ns/1ps
`default_nettype none
module lcddmc_scan #(
	parameter int DIV0 = lcddmc_pkg::LINE_DIV_0,
	parameter int DIV1 = lcddmc_pkg::LINE_DIV_1,
	parameter int DIV2 = lcddmc_pkg::LINE_DIV_2,
	parameter int DIV3 = lcddmc_pkg::LINE_DIV_3
) (
	input wire logic clk,
	input wire logic rst_n,
	lcddmc_scan_if.scan sc
);
	logic [lcddmc_pkg::DIV_W-1:0] cnt_r;
	logic [lcddmc_pkg::DIV_W-1:0] base;
	logic [lcddmc_pkg::DIV_W-1:0] limit;
	logic tickNow;
	logic wrapNow;

	// frame clock rate picks the line period
	assign base = (sc.frameSel == 2'h0) ? lcddmc_pkg::DIV_W'(DIV0) :
		(sc.frameSel == 2'h1) ? lcddmc_pkg::DIV_W'(DIV1) :
		(sc.frameSel == 2'h2) ? lcddmc_pkg::DIV_W'(DIV2) : lcddmc_pkg::DIV_W'(DIV3);
	assign limit = sc.halfRate ? lcddmc_pkg::DIV_W'({base, 1'b0}) : base;
	assign tickNow = (cnt_r >= limit - lcddmc_pkg::DIV_W'(1));
	assign wrapNow = (sc.comIdx >= sc.lastCom);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_r <= '0;
			sc.comIdx <= '0;
			sc.lineTick <= 1'b0;
			sc.frameStart <= 1'b0;
		end
		else
		begin
			cnt_r <= tickNow ? '0 : cnt_r + lcddmc_pkg::DIV_W'(1);
			sc.lineTick <= tickNow;
			sc.frameStart <= tickNow && wrapNow;
			if (tickNow)
				sc.comIdx <= wrapNow ? 5'h0 : sc.comIdx + 5'h1;
		end
	end

	sequence lastLineTick;
		tickNow ##0 wrapNow;
	endsequence

	scan_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
		lastLineTick |=> (sc.comIdx == 5'h0) && sc.frameStart)
		else $error("scan did not wrap to first common");
	scan_step_a: assert property (@(posedge clk) disable iff (!rst_n)
		tickNow && !wrapNow |=> sc.comIdx == $past(sc.comIdx) + 5'h1 && sc.lineTick)
		else $error("common index did not advance");
endmodule
`default_nettype wire

// ### rtl/lcddmc_top.sv
// lcd dot-matrix control: apb registers, display memory, panel drive
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lcddmc_top #(
	parameter int ADDR_W = 18,
	parameter int LINE_DIV0 = lcddmc_pkg::LINE_DIV_0,
	parameter int LINE_DIV1 = lcddmc_pkg::LINE_DIV_1,
	parameter int LINE_DIV2 = lcddmc_pkg::LINE_DIV_2,
	parameter int LINE_DIV3 = lcddmc_pkg::LINE_DIV_3,
	parameter int BOOST_DIV = lcddmc_pkg::BOOST_DIV
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [47:0] segPin_r,
	output logic [31:0] comPin_r,
	output logic staticDrive_r,
	output logic regulatorOn_r,
	output logic [3:0] contrastOut_r,
	output logic boosterOn_r,
	output logic sourceBoost_r,
	output logic lcdHeavyLoad_r,
	output logic logicHeavyLoad_r,
	output logic boostClk_r
);
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [3:0] ctrl_r [lcddmc_pkg::NREGS];
	logic [3:0] dispMem [lcddmc_pkg::MEM_WORDS];
	logic [15:0] boostCnt_r;

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// apb decode
	logic [15:0] regIdx;
	logic [lcddmc_pkg::NREGS-1:0] regHit;
	logic memHit;
	logic [8:0] memAddr;
	logic setupPhase;
	logic accessDone;
	logic wrDone;
	logic [3:0] regRead;
	assign regIdx = paddr[17:2];
	assign regHit[lcddmc_pkg::R_SUPPLY] = regIdx == lcddmc_pkg::IDX_SUPPLY;
	assign regHit[lcddmc_pkg::R_REGUL] = regIdx == lcddmc_pkg::IDX_REGUL;
	assign regHit[lcddmc_pkg::R_CLKSEL] = regIdx == lcddmc_pkg::IDX_CLKSEL;
	assign regHit[lcddmc_pkg::R_MODE] = regIdx == lcddmc_pkg::IDX_MODE;
	assign regHit[lcddmc_pkg::R_DUTY] = regIdx == lcddmc_pkg::IDX_DUTY;
	assign regHit[lcddmc_pkg::R_CONTRAST] = regIdx == lcddmc_pkg::IDX_CONTRAST;
	// holes of the memory window answer with an error
	assign memHit = (regIdx[15:10] == lcddmc_pkg::MEM_PAGE_HI)
		&& !regIdx[lcddmc_pkg::MEM_HOLE_BIT];
	assign memAddr = {regIdx[9:8], regIdx[6:0]};
	assign setupPhase = psel && !penable && !pready_r;
	assign accessDone = psel && penable && pready_r;
	assign wrDone = accessDone && pwrite;

	always_comb
	begin
		regRead = 4'h0;
		for (int i = 0; i < lcddmc_pkg::NREGS; i++)
			if (regHit[i])
				regRead = ctrl_r[i];
	end

	// apb answer: ready in the cycle after setup
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= setupPhase;
			if (setupPhase)
			begin
				prdata_r <= {28'h000_0000, memHit ? dispMem[memAddr] : regRead};
				pslverr_r <= !memHit && (regHit == '0);
			end
		end
	end

	// control registers; spare and general bits just store
	genvar r;
	generate
		for (r = 0; r < lcddmc_pkg::NREGS; r++)
		begin : g_reg
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					ctrl_r[r] <= lcddmc_pkg::REG_RESET;
				else if (wrDone && regHit[r])
					ctrl_r[r] <= pwdata[3:0];
			end
		end
	endgenerate

	// display memory, not reset, any mode leaves it alone
	always_ff @(posedge clk)
	begin
		if (wrDone && memHit)
			dispMem[memAddr] <= pwdata[3:0];
	end

	// field views
	logic [2:0] dutyCode;
	logic [1:0] boostSel;
	lcddmc_pkg::lcddmc_mode_t mode;
	logic pageSel;
	logic duty16;
	logic duty24;
	assign dutyCode = ctrl_r[lcddmc_pkg::R_DUTY][2:0];
	assign boostSel = ctrl_r[lcddmc_pkg::R_CLKSEL][lcddmc_pkg::BOOST_SEL_LO +: 2];
	assign mode = lcddmc_pkg::lcddmc_mode_t'(ctrl_r[lcddmc_pkg::R_MODE][lcddmc_pkg::MODE_LO +: 2]);
	assign pageSel = ctrl_r[lcddmc_pkg::R_MODE][lcddmc_pkg::PAGE_BIT];
	assign duty16 = dutyCode == lcddmc_pkg::DUTY_16;
	assign duty24 = (dutyCode == lcddmc_pkg::DUTY_24A) || (dutyCode == lcddmc_pkg::DUTY_24B);

	// scanner
	lcddmc_scan_if sc ();
	assign sc.frameSel = ctrl_r[lcddmc_pkg::R_CLKSEL][lcddmc_pkg::FRAME_SEL_LO +: 2];
	assign sc.halfRate = duty16 || (dutyCode == lcddmc_pkg::DUTY_24B);
	assign sc.lastCom = duty16 ? lcddmc_pkg::LAST_COM_16 :
		duty24 ? lcddmc_pkg::LAST_COM_24 : lcddmc_pkg::LAST_COM_32;

	lcddmc_scan #(
		.DIV0(LINE_DIV0),
		.DIV1(LINE_DIV1),
		.DIV2(LINE_DIV2),
		.DIV3(LINE_DIV3)
	) u_scan (
		.clk(clk),
		.rst_n(rst_n),
		.sc(sc)
	);

	// memory block for the active common
	logic [1:0] blkSel;
	assign blkSel = duty16 ? {pageSel, sc.comIdx[3]} : sc.comIdx[4:3];

	// pixel row and segment levels
	logic [lcddmc_pkg::NSEG-1:0] pixelRow;
	logic [lcddmc_pkg::NSEG-1:0] segVal;
	logic [lcddmc_pkg::NCOM-1:0] comVal;
	logic [47:0] segPinNxt;
	logic [31:0] comPinNxt;
	logic driveOn;
	assign driveOn = ctrl_r[lcddmc_pkg::R_REGUL][lcddmc_pkg::REGUL_EN_BIT];

	genvar s;
	generate
		for (s = 0; s < lcddmc_pkg::NSEG; s++)
		begin : g_seg
			assign pixelRow[s] = dispMem[{blkSel, 6'(s), sc.comIdx[2]}][sc.comIdx[1:0]];
		end
	endgenerate

	always_comb
	begin
		case (mode)
			lcddmc_pkg::MODE_NORMAL: segVal = pixelRow;
			lcddmc_pkg::MODE_REVERSE: segVal = ~pixelRow;
			lcddmc_pkg::MODE_ALL_ON: segVal = '1;
			lcddmc_pkg::MODE_ALL_OFF: segVal = '0;
			default: segVal = pixelRow;
		endcase
		comVal = '0;
		if (mode == lcddmc_pkg::MODE_ALL_ON)
			comVal = '1;
		else
			comVal[sc.comIdx] = 1'b1;
	end

	assign segPinNxt = driveOn ? segVal[47:0] : '0;

	// spare common pins carry segments 48.. in reverse pin order
	genvar k;
	generate
		for (k = 0; k < lcddmc_pkg::NCOM; k++)
		begin : g_com
			if (k < 16)
			begin : g_low
				assign comPinNxt[k] = driveOn && comVal[k];
			end
			else
			begin : g_high
				logic asSeg;
				assign asSeg = duty16 || (duty24 && k >= 24);
				assign comPinNxt[k] = driveOn && (asSeg ?
					segVal[lcddmc_pkg::SEG_EXTRA + 31 - k] : comVal[k]);
			end
		end
	endgenerate

	// panel and supply outputs
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			segPin_r <= '0;
			comPin_r <= '0;
			staticDrive_r <= 1'b0;
			regulatorOn_r <= 1'b0;
			contrastOut_r <= 4'h0;
			boosterOn_r <= 1'b0;
			sourceBoost_r <= 1'b0;
			lcdHeavyLoad_r <= 1'b0;
			logicHeavyLoad_r <= 1'b0;
		end
		else
		begin
			segPin_r <= segPinNxt;
			comPin_r <= comPinNxt;
			staticDrive_r <= mode == lcddmc_pkg::MODE_ALL_ON;
			regulatorOn_r <= driveOn;
			contrastOut_r <= driveOn ? ctrl_r[lcddmc_pkg::R_CONTRAST] : 4'h0;
			boosterOn_r <= ctrl_r[lcddmc_pkg::R_SUPPLY][lcddmc_pkg::BOOSTER_EN_BIT];
			sourceBoost_r <= ctrl_r[lcddmc_pkg::R_SUPPLY][lcddmc_pkg::SRC_SEL_BIT];
			lcdHeavyLoad_r <= ctrl_r[lcddmc_pkg::R_REGUL][lcddmc_pkg::LCD_HL_BIT];
			logicHeavyLoad_r <= ctrl_r[lcddmc_pkg::R_REGUL][lcddmc_pkg::LOGIC_HL_BIT];
		end
	end

	// 2 kHz boost clock, only for select code 01
	logic boostHalf;
	assign boostHalf = boostCnt_r >= 16'(BOOST_DIV - 1);
	always_ff @(posedge clk)
	begin
		if (!rst_n || boostSel != lcddmc_pkg::BOOST_ON)
		begin
			boostCnt_r <= 16'h0000;
			boostClk_r <= 1'b0;
		end
		else
		begin
			boostCnt_r <= boostHalf ? 16'h0000 : boostCnt_r + 16'h0001;
			if (boostHalf)
				boostClk_r <= !boostClk_r;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence regWrite(int n);
		wrDone && regHit[n];
	endsequence

	apb_ready_a: assert property (setupPhase |=> pready_r ##1 !pready_r)
		else $error("apb ready not a single cycle after setup");
	apb_error_a: assert property (setupPhase && !memHit && (regHit == '0) |=> pslverr_r)
		else $error("unmapped access not flagged");
	reset_zero_a: assert property (!$past(rst_n) |-> regulatorOn_r == 1'b0
		&& contrastOut_r == 4'h0 && ctrl_r[lcddmc_pkg::R_DUTY] == 4'h0)
		else $error("control state not zero after reset");
	page_sel_a: assert property (duty16 |-> blkSel[1] == pageSel)
		else $error("page bit not steering block at 1/16");
	page_plain_a: assert property (!duty16 |-> blkSel == sc.comIdx[4:3])
		else $error("page bit affects display outside 1/16");
	reg_off_a: assert property (regWrite(lcddmc_pkg::R_REGUL) ##0 !pwdata[0]
		|=> ##1 !regulatorOn_r && contrastOut_r == 4'h0 && segPin_r == '0)
		else $error("drive not grounded after regulator off");
	contrast_out_a: assert property (regWrite(lcddmc_pkg::R_CONTRAST) ##0 driveOn
		|=> ##1 contrastOut_r == $past(pwdata[3:0], 2))
		else $error("contrast code not applied");
	booster_rb_a: assert property (regWrite(lcddmc_pkg::R_SUPPLY)
		|=> ##1 boosterOn_r == $past(pwdata[0], 2))
		else $error("booster enable not following write");
	boost_off_a: assert property ((boostSel != lcddmc_pkg::BOOST_ON) [*2] |-> !boostClk_r)
		else $error("boost clock running while not selected");
	all_on_a: assert property (driveOn && mode == lcddmc_pkg::MODE_ALL_ON
		|=> staticDrive_r && (&segPin_r) && (&comPin_r[15:0]))
		else $error("all-on mode not static full drive");
	all_off_a: assert property (mode == lcddmc_pkg::MODE_ALL_OFF
		|=> !staticDrive_r && segPin_r == '0 && $onehot0(comPin_r[15:0]))
		else $error("all-off mode not dynamic blank");
	reverse_a: assert property (driveOn && mode == lcddmc_pkg::MODE_REVERSE
		|=> segPin_r == ~$past(pixelRow[47:0]))
		else $error("reverse mode output wrong");
	normal_a: assert property (driveOn && mode == lcddmc_pkg::MODE_NORMAL
		|=> segPin_r == $past(pixelRow[47:0]))
		else $error("normal mode output wrong");
endmodule
`default_nettype wire

// ### verification/lcddmc_panel.sv
// panel model: latches what each active common line shows
`timescale 1ns/1ps
`default_nettype none
module lcddmc_panel (
	input wire logic clk,
	input wire logic [47:0] segPin,
	input wire logic [31:0] comPin,
	input wire logic [5:0] numCom,
	output logic [79:0] seen [32],
	output int seqErrors
);
	int act;
	int prev = -1;
	int held = 0;
	initial seqErrors = 0;
	always @(posedge clk)
	begin
		act = -1;
		for (int i = 0; i < int'(numCom); i++)
			if (comPin[i] === 1'b1)
				act = i;
		held = (act == prev) ? held + 1 : 0;
		if (act != prev && act >= 0 && prev >= 0 && act != (prev + 1) % int'(numCom))
			seqErrors++;
		if (held == 3 && act >= 0)
			seen[act] = {comPin, segPin};
		prev = act;
	end
endmodule
`default_nettype wire

// ### verification/lcddmc_top_test.sv
// self-checking bench for the lcd dot-matrix control block
`timescale 1ns/1ps
`default_nettype none
module lcddmc_top_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [47:0] segPin_r;
	logic [31:0] comPin_r;
	logic staticDrive_r;
	logic regulatorOn_r;
	logic [3:0] contrastOut_r;
	logic boosterOn_r;
	logic sourceBoost_r;
	logic lcdHeavyLoad_r;
	logic logicHeavyLoad_r;
	logic boostClk_r;
	logic [5:0] numCom = 6'h20;
	logic [79:0] seen [32];
	int seqErrors;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	int t;
	logic [31:0] rd;
	logic err;
	int tD [7] = '{0, 0, 0, 0, 2, 3, 4};
	int tF [7] = '{0, 1, 2, 3, 1, 1, 2};
	int tE [7] = '{8, 12, 16, 32, 12, 24, 32};
	always #5 clk = ~clk;
	lcddmc_top #(.LINE_DIV0(8), .LINE_DIV1(12), .LINE_DIV2(16), .LINE_DIV3(32),
		.BOOST_DIV(4)) i_lcddmc_top (.clk, .rst_n, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .segPin_r, .comPin_r, .staticDrive_r,
		.regulatorOn_r, .contrastOut_r, .boosterOn_r, .sourceBoost_r, .lcdHeavyLoad_r,
		.logicHeavyLoad_r, .boostClk_r);
	lcddmc_panel i_lcddmc_panel (.clk, .segPin(segPin_r), .comPin(comPin_r), .numCom,
		.seen, .seqErrors);
	task automatic complete_run();
		$display("Checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			mismatches++;
			complete_run();
		end
	end
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [3:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {28'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [3:0] d);
		apb(1'b1, idx, d);
		repeat (2) @(posedge clk);
	endtask
	task automatic rchk(input logic [15:0] idx, input logic [3:0] e);
		apb(1'b0, idx, 4'h0);
		chk({err, rd}, {1'b0, 28'h0, e});
	endtask
	function automatic logic [3:0] pat(int b, int s, int h);
		return 4'(s + 3 * b + 5 * h);
	endfunction
	function automatic logic [15:0] madr(int b, int s, int h);
		return 16'(32'hF000 + b * 256 + s * 2 + h);
	endfunction
	function automatic logic [79:0] view(int c, int p16, int pg, logic inv);
		logic [79:0] v;
		logic [3:0] w;
		int b;
		v = 80'h0;
		b = p16 ? pg * 2 + c / 8 % 2 : c / 8;
		v[48 + c] = 1'b1;
		for (int s = 0; s < 64; s++)
		begin
			w = pat(b, s, c / 4 % 2);
			if (s < 48)
				v[s] = w[c % 4] ^ inv;
			else if (p16)
				v[79 - (s - 48)] = w[c % 4] ^ inv;
		end
		return v;
	endfunction
	task automatic frame(input int p16, input int pg, input logic inv);
		int s0;
		s0 = seqErrors;
		repeat (600) @(posedge clk);
		for (int c = 0; c < int'(numCom); c++)
			chk(seen[c], view(c, p16, pg, inv));
		chk(seqErrors - s0, 0);
	endtask
	task automatic period(input int e);
		int n;
		for (n = 0; comPin_r[1] !== 1'b0 && n < 3000; n++) @(posedge clk);
		for (n = 0; comPin_r[1] !== 1'b1 && n < 3000; n++) @(posedge clk);
		for (n = 0; comPin_r[2] !== 1'b1 && n < 3000; n++) @(posedge clk);
		chk(n, e);
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({contrastOut_r, comPin_r, segPin_r}, 96'h0);
		chk({staticDrive_r, regulatorOn_r, boosterOn_r, boostClk_r}, 96'h0);
		rchk(lcddmc_pkg::IDX_SUPPLY, 4'h0);
		rchk(lcddmc_pkg::IDX_REGUL, 4'h0);
		rchk(lcddmc_pkg::IDX_CLKSEL, 4'h0);
		rchk(lcddmc_pkg::IDX_MODE, 4'h0);
		rchk(lcddmc_pkg::IDX_DUTY, 4'h0);
		rchk(lcddmc_pkg::IDX_CONTRAST, 4'h0);
		apb(1'b0, 16'hFF04, 4'h0);
		chk({err, rd}, {1'b1, 32'h0});
		apb(1'b1, 16'hFF53, 4'hF);
		chk(err, 1'b1);
		for (int b = 0; b < 4; b++)
			for (int s = 0; s < 64; s++)
				for (int h = 0; h < 2; h++)
					wr(madr(b, s, h), pat(b, s, h));
		wr(lcddmc_pkg::IDX_SUPPLY, 4'hB);
		rchk(lcddmc_pkg::IDX_SUPPLY, 4'hB);
		chk({boosterOn_r, sourceBoost_r}, 2'h2);
		repeat (100) @(posedge clk);
		wr(lcddmc_pkg::IDX_SUPPLY, 4'h5);
		chk({boosterOn_r, sourceBoost_r}, 2'h3);
		wr(lcddmc_pkg::IDX_CLKSEL, 4'h1);
		toggles(t);
		chk(t, 10);
		wr(lcddmc_pkg::IDX_REGUL, 4'hF);
		rchk(lcddmc_pkg::IDX_REGUL, 4'hF);
		chk({regulatorOn_r, lcdHeavyLoad_r, logicHeavyLoad_r}, 3'h7);
		wr(lcddmc_pkg::IDX_CONTRAST, 4'hA);
		chk(contrastOut_r, 4'hA);
		wr(lcddmc_pkg::IDX_REGUL, 4'hE);
		chk({regulatorOn_r, contrastOut_r, comPin_r, segPin_r}, 96'h0);
		wr(lcddmc_pkg::IDX_REGUL, 4'hF);
		repeat (20) @(posedge clk);
		frame(0, 0, 1'b0);
		wr(lcddmc_pkg::IDX_MODE, 4'h1);
		frame(0, 0, 1'b1);
		wr(lcddmc_pkg::IDX_MODE, 4'h2);
		chk(staticDrive_r, 1'b1);
		wr(lcddmc_pkg::IDX_MODE, 4'h3);
		repeat (20) @(posedge clk);
		chk({staticDrive_r, segPin_r, comPin_r == 32'h0}, 96'h0);
		wr(lcddmc_pkg::IDX_MODE, 4'hC);
		rchk(lcddmc_pkg::IDX_MODE, 4'hC);
		frame(0, 0, 1'b0);
		numCom <= 6'h10;
		wr(lcddmc_pkg::IDX_DUTY, 4'h4);
		frame(1, 1, 1'b0);
		wr(lcddmc_pkg::IDX_MODE, 4'h0);
		frame(1, 0, 1'b0);
		for (int b = 0; b < 4; b++)
			rchk(madr(b, 47, 1), pat(b, 47, 1));
		for (int i = 0; i < 7; i++)
		begin
			wr(lcddmc_pkg::IDX_DUTY, 4'(tD[i]));
			wr(lcddmc_pkg::IDX_CLKSEL, {2'(tF[i]), 2'h1});
			period(tE[i]);
		end
		wr(lcddmc_pkg::IDX_SUPPLY, 4'h0);
		chk({boosterOn_r, sourceBoost_r}, 2'h0);
		complete_run();
	end
	task automatic toggles(output int n);
		logic last;
		n = 0;
		last = boostClk_r;
		repeat (40)
		begin
			@(posedge clk);
			if (boostClk_r !== last)
				n++;
			last = boostClk_r;
		end
	endtask
endmodule
`default_nettype wire
